/* logic/pat_pkg.sv */
`default_nettype none
package pat_pkg;

	// ==========================================================
	// Address geometry
	localparam int EA_W      = 18;
	localparam int PA_W      = 22;
	localparam int PAGE_W    = 9;
	localparam int OFF_W     = 9;
	localparam int FRAME_W   = 13;
	localparam int ACC_W     = 3;
	localparam int KEY_W     = 10;
	localparam int FAST_W    = 4;

	// ==========================================================
	// Associative map
	localparam int ENTRIES       = 32;
	localparam int ENT_W         = 16;
	localparam int ENT_FRAME_LSB = 0;
	localparam int ENT_ACC_LSB   = 13;
	localparam logic [4:0] RELOAD_RESET = 5'h00;

	// Highest address served by the fast register block
	localparam logic [17:0] FAST_LAST = 18'h0_000F;

	// ==========================================================
	// Access-type codes
	localparam logic [2:0] ACC_NONE    = 3'h0;
	localparam logic [2:0] ACC_RO      = 3'h1;
	localparam logic [2:0] ACC_RX      = 3'h2;
	localparam logic [2:0] ACC_RW      = 3'h3;
	localparam logic [2:0] ACC_XO_PROP = 3'h4;
	localparam logic [2:0] ACC_RWX     = 3'h5;

	typedef enum logic [1:0] {
		PAT_RD = 2'h0,
		PAT_WR = 2'h1,
		PAT_EX = 2'h2
	} pat_kind_type;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'h1,
		ST_LOOK  = 3'h2,
		ST_FETCH = 3'h4
	} pat_state_type;

endpackage
`default_nettype wire

/* logic/pat_cam_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface pat_cam_if #(
	parameter int KEY_W = 10,
	parameter int ENT_W = 16,
	parameter int IDX_W = 5
);
	logic [KEY_W-1:0] lookup_key;
	logic             hit;
	logic [IDX_W-1:0] hit_idx;
	logic [ENT_W-1:0] hit_data;
	logic             wr_en;
	logic [IDX_W-1:0] wr_idx;
	logic [KEY_W-1:0] wr_key;
	logic [ENT_W-1:0] wr_data;

	modport ctl (output lookup_key, input hit, input hit_idx, input hit_data,
		output wr_en, output wr_idx, output wr_key, output wr_data);
	modport mem (input lookup_key, output hit, output hit_idx, output hit_data,
		input wr_en, input wr_idx, input wr_key, input wr_data);
endinterface
`default_nettype wire

/* logic/pat_assoc_mem.sv */
`timescale 1ns/100ps
`default_nettype none
module pat_assoc_mem #(
	parameter int ENTRIES = 32,
	parameter int KEY_W   = 10,
	parameter int ENT_W   = 16,
	parameter int IDX_W   = 5
) (
	input  wire logic mclk,
	input  wire logic rst,
	pat_cam_if.mem    cam
);

	logic [ENTRIES-1:0] valid_q;
	logic [ENTRIES-1:0] valid_d;
	logic [KEY_W-1:0]   key_q  [ENTRIES];
	logic [KEY_W-1:0]   key_d  [ENTRIES];
	logic [ENT_W-1:0]   data_q [ENTRIES];
	logic [ENT_W-1:0]   data_d [ENTRIES];
	logic [ENTRIES-1:0] match;

	// ==========================================================
	// Compare key against every entry
	genvar g;
	generate
		for (g = 0; g < ENTRIES; g++) begin : g_cmp
			assign match[g] = valid_q[g] && (key_q[g] == cam.lookup_key); // RL6
		end
	endgenerate

	always_comb begin
		cam.hit     = 1'b0;
		cam.hit_idx = '0;
		for (int i = 0; i < ENTRIES; i++) begin
			if (match[i] && !cam.hit) begin
				cam.hit     = 1'b1;
				cam.hit_idx = IDX_W'(i);
			end
		end
		cam.hit_data = data_q[cam.hit_idx];
	end

	// ==========================================================
	// Entry storage
	always_comb begin
		valid_d = valid_q;
		key_d   = key_q;
		data_d  = data_q;
		if (rst) begin
			valid_d = '0; // RL14
		end else if (cam.wr_en) begin
			valid_d[cam.wr_idx] = 1'b1;
			key_d[cam.wr_idx]   = cam.wr_key;
			data_d[cam.wr_idx]  = cam.wr_data;
		end
	end

	always_ff @(posedge mclk) begin
		valid_q <= valid_d;
		key_q   <= key_d;
		data_q  <= data_d;
	end

	a_match_unique: assert property (@(posedge mclk) disable iff (rst) $onehot0(match)) // RL6
		else $error("more than one associative entry matched");

endmodule
`default_nettype wire

/* logic/pat_access_check.sv */
`timescale 1ns/100ps
`default_nettype none
module pat_access_check (
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic [2:0] acc_code,
	input  wire logic [1:0] kind,
	output logic            permit
);

	// Proprietary pages allow instruction fetch only, never data reads
	function automatic logic acc_permits(input logic [2:0] code, input logic [1:0] k);
		logic rd;
		logic wr;
		logic ex;
		rd = (k == pat_pkg::PAT_RD);
		wr = (k == pat_pkg::PAT_WR);
		ex = (k == pat_pkg::PAT_EX);
		case (code)
			pat_pkg::ACC_RO:      acc_permits = rd;
			pat_pkg::ACC_RX:      acc_permits = rd || ex;
			pat_pkg::ACC_RW:      acc_permits = rd || wr;
			pat_pkg::ACC_XO_PROP: acc_permits = ex;
			pat_pkg::ACC_RWX:     acc_permits = rd || wr || ex;
			default:              acc_permits = 1'b0; // RL12
		endcase
	endfunction

	assign permit = acc_permits(acc_code, kind); // RL4

	a_zero_denies: assert property (@(posedge mclk) disable iff (rst) // RL12
		(acc_code == pat_pkg::ACC_NONE) |-> !permit)
		else $error("zero access code permitted a request");

endmodule
`default_nettype wire

/* logic/pat_translator.sv */
// Functional notes
// [RL1] Effective addresses are 18 bits and physical addresses are 22 bits.
// [RL2] The upper 9 address bits index the user map or the executive map chosen by mode.
// [RL3] A permitted access forms the physical address from the 13-bit frame and the low 9 bits.
// [RL4] Each map entry carries a 3-bit access code saying which request kinds are allowed.
// [RL5] Addresses 0 to 17 octal go to the fast register block and are never translated.
// [RL6] The 10-bit key of mode bit and page index matches at most one associative entry.
// [RL7] A hit whose access code forbids the request raises a page failure, not an access.
// [RL8] A miss fetches the entry from the in-memory page table and installs it first.
// [RL9] The associative memory holds 32 entries and a reload counter always points at one.
// [RL10] A hit on the entry under the reload counter advances the counter by one.
// [RL11] A fetched entry overwrites the entry the reload counter points at.
// [RL12] An access code of zero makes any reference to the page a page failure.
// [RL13] Translation works on pages of 512 words, the 9 untranslated low bits.
// [RL14] The reload counter wraps to zero, and reset clears it and invalidates all entries.
// [RL15] A page failure reports the address and mode bit and starts no memory access.
`timescale 1ns/100ps
`default_nettype none
module pat_translator #(
	parameter int ENTRIES = pat_pkg::ENTRIES
) (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        req_valid,
	output logic             req_ready,
	input  wire logic [17:0] req_addr,
	input  wire logic        req_user,
	input  wire logic [1:0]  req_kind,
	input  wire logic [12:0] user_map_base,
	input  wire logic [12:0] exec_map_base,
	output logic             pt_req_valid,
	output logic [21:0]      pt_req_addr,
	input  wire logic        pt_rsp_valid,
	input  wire logic [15:0] pt_rsp_data,
	output logic             phys_valid,
	output logic [21:0]      phys_addr,
	output logic             fast_valid,
	output logic [3:0]       fast_idx,
	output logic             fail_valid,
	output logic [17:0]      fail_addr,
	output logic             fail_user,
	output logic [2:0]       fail_code,
	output logic [4:0]       reload_ptr
);

	localparam int IDX_W = $clog2(ENTRIES);

	// ==========================================================
	// Declarations
	pat_pkg::pat_state_type state_q;
	pat_pkg::pat_state_type state_d;
	logic [17:0]            ea_q;
	logic [17:0]            ea_d;
	logic                   user_q;
	logic                   user_d;
	logic [1:0]             kind_q;
	logic [1:0]             kind_d;
	logic [21:0]            pt_addr_q;
	logic [21:0]            pt_addr_d;
	logic [IDX_W-1:0]       reload_q;
	logic [IDX_W-1:0]       reload_d;

	logic                   phys_valid_q;
	logic                   phys_valid_d;
	logic [21:0]            phys_addr_q;
	logic [21:0]            phys_addr_d;
	logic                   fast_valid_q;
	logic                   fast_valid_d;
	logic [3:0]             fast_idx_q;
	logic [3:0]             fast_idx_d;
	logic                   fail_valid_q;
	logic                   fail_valid_d;
	logic [17:0]            fail_addr_q;
	logic [17:0]            fail_addr_d;
	logic                   fail_user_q;
	logic                   fail_user_d;
	logic [2:0]             fail_code_q;
	logic [2:0]             fail_code_d;

	logic                   in_look;
	logic                   is_fast;
	logic                   permit;
	logic [12:0]            hit_frame;
	logic [2:0]             hit_acc;
	logic [12:0]            map_base;
	logic                   look_hit;
	logic                   look_miss;

	pat_cam_if #(
		.KEY_W (pat_pkg::KEY_W),
		.ENT_W (pat_pkg::ENT_W),
		.IDX_W (IDX_W)
	) cam ();

	// ==========================================================
	// Associative map and access decode
	pat_assoc_mem #(
		.ENTRIES (ENTRIES),
		.KEY_W   (pat_pkg::KEY_W),
		.ENT_W   (pat_pkg::ENT_W),
		.IDX_W   (IDX_W)
	) u_map (
		.mclk (mclk),
		.rst  (rst),
		.cam  (cam.mem)
	);

	pat_access_check u_acc (
		.mclk     (mclk),
		.rst      (rst),
		.acc_code (hit_acc),
		.kind     (kind_q),
		.permit   (permit)
	);

	assign cam.lookup_key = {user_q, ea_q[17:9]}; // RL6 RL2
	assign hit_frame = cam.hit_data[pat_pkg::ENT_FRAME_LSB +: pat_pkg::FRAME_W];
	assign hit_acc   = cam.hit_data[pat_pkg::ENT_ACC_LSB +: pat_pkg::ACC_W]; // RL4
	assign map_base  = user_q ? user_map_base : exec_map_base; // RL2

	assign in_look   = (state_q == pat_pkg::ST_LOOK);
	assign is_fast   = (ea_q <= pat_pkg::FAST_LAST); // RL5
	assign look_hit  = in_look && !is_fast && cam.hit;
	assign look_miss = in_look && !is_fast && !cam.hit;

	// Install straight from the page-table answer into the slot under the counter
	assign cam.wr_en   = (state_q == pat_pkg::ST_FETCH) && pt_rsp_valid; // RL8
	assign cam.wr_idx  = reload_q; // RL11
	assign cam.wr_key  = {user_q, ea_q[17:9]};
	assign cam.wr_data = pt_rsp_data;

	// ==========================================================
	// Request sequencing
	always_comb begin
		state_d   = state_q;
		ea_d      = ea_q;
		user_d    = user_q;
		kind_d    = kind_q;
		pt_addr_d = pt_addr_q;
		case (state_q)
			pat_pkg::ST_IDLE: begin
				if (req_valid) begin
					ea_d    = req_addr; // RL1
					user_d  = req_user;
					kind_d  = req_kind;
					state_d = pat_pkg::ST_LOOK;
				end
			end
			pat_pkg::ST_LOOK: begin
				if (look_miss) begin
					pt_addr_d = {map_base, ea_q[17:9]}; // RL8 RL2
					state_d   = pat_pkg::ST_FETCH;
				end else begin
					state_d = pat_pkg::ST_IDLE;
				end
			end
			pat_pkg::ST_FETCH: begin
				// Re-run the lookup so the fresh entry is checked like any hit
				if (pt_rsp_valid) begin
					state_d = pat_pkg::ST_LOOK; // RL8
				end
			end
			default: begin
				state_d = pat_pkg::ST_IDLE;
			end
		endcase
		if (rst) begin
			state_d   = pat_pkg::ST_IDLE;
			ea_d      = '0;
			user_d    = 1'b0;
			kind_d    = pat_pkg::PAT_RD;
			pt_addr_d = '0;
		end
	end

	always_ff @(posedge mclk) begin
		state_q   <= state_d;
		ea_q      <= ea_d;
		user_q    <= user_d;
		kind_q    <= kind_d;
		pt_addr_q <= pt_addr_d;
	end

	// ==========================================================
	// Reload counter
	// Pushed away from pages in use, so it lingers on stale entries
	always_comb begin
		reload_d = reload_q;
		if (look_hit && (cam.hit_idx == reload_q)) begin
			reload_d = IDX_W'(reload_q + 1'b1); // RL10 RL14
		end
		if (rst) begin
			reload_d = IDX_W'(pat_pkg::RELOAD_RESET); // RL14
		end
	end

	always_ff @(posedge mclk) begin
		reload_q <= reload_d; // RL9
	end

	// ==========================================================
	// Results
	always_comb begin
		phys_valid_d = 1'b0;
		fast_valid_d = 1'b0;
		fail_valid_d = 1'b0;
		phys_addr_d  = phys_addr_q;
		fast_idx_d   = fast_idx_q;
		fail_addr_d  = fail_addr_q;
		fail_user_d  = fail_user_q;
		fail_code_d  = fail_code_q;
		if (in_look && is_fast) begin
			fast_valid_d = 1'b1; // RL5
			fast_idx_d   = ea_q[3:0];
		end else if (look_hit && permit) begin
			phys_valid_d = 1'b1;
			phys_addr_d  = {hit_frame, ea_q[8:0]}; // RL3 RL13
		end else if (look_hit) begin
			fail_valid_d = 1'b1; // RL7 RL12
			fail_addr_d  = ea_q; // RL15
			fail_user_d  = user_q;
			fail_code_d  = hit_acc;
		end
		if (rst) begin
			phys_valid_d = 1'b0;
			fast_valid_d = 1'b0;
			fail_valid_d = 1'b0;
			phys_addr_d  = '0;
			fast_idx_d   = '0;
			fail_addr_d  = '0;
			fail_user_d  = 1'b0;
			fail_code_d  = '0;
		end
	end

	always_ff @(posedge mclk) begin
		phys_valid_q <= phys_valid_d;
		phys_addr_q  <= phys_addr_d;
		fast_valid_q <= fast_valid_d;
		fast_idx_q   <= fast_idx_d;
		fail_valid_q <= fail_valid_d;
		fail_addr_q  <= fail_addr_d;
		fail_user_q  <= fail_user_d;
		fail_code_q  <= fail_code_d;
	end

	// ==========================================================
	// Outputs
	assign req_ready    = (state_q == pat_pkg::ST_IDLE);
	assign pt_req_valid = (state_q == pat_pkg::ST_FETCH);
	assign pt_req_addr  = pt_addr_q;
	assign phys_valid   = phys_valid_q;
	assign phys_addr    = phys_addr_q;
	assign fast_valid   = fast_valid_q;
	assign fast_idx     = fast_idx_q;
	assign fail_valid   = fail_valid_q;
	assign fail_addr    = fail_addr_q;
	assign fail_user    = fail_user_q;
	assign fail_code    = fail_code_q;
	assign reload_ptr   = 5'(reload_q);

	// ==========================================================
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	sequence s_install;
		cam.wr_en;
	endsequence

	sequence s_hit_at_slot;
		look_hit && (cam.hit_idx == $past(reload_q));
	endsequence

	a_fast_bypass: assert property ( // RL5
		(in_look && is_fast) |=> fast_valid && !phys_valid && !fail_valid && !pt_req_valid)
		else $error("fast register address was not bypassed");

	a_phys_form: assert property ( // RL3
		(look_hit && permit) |=> phys_valid && (phys_addr == {$past(hit_frame), $past(ea_q[8:0])}))
		else $error("physical address not formed from frame and offset");

	a_deny_fails: assert property ( // RL7
		(look_hit && !permit) |=> fail_valid && !phys_valid && (fail_code == $past(hit_acc)))
		else $error("forbidden access did not raise a page failure");

	a_zero_code_trap: assert property ( // RL12
		(look_hit && (hit_acc == pat_pkg::ACC_NONE)) |=> fail_valid && !phys_valid)
		else $error("zero access code did not trap");

	a_fail_report: assert property ( // RL15
		fail_valid |-> (fail_addr == $past(ea_q)) && (fail_user == $past(user_q)) && !phys_valid)
		else $error("page failure report does not match the request");

	a_miss_fetch: assert property ( // RL8
		look_miss |=> pt_req_valid
			&& (pt_req_addr == {($past(user_q) ? $past(user_map_base) : $past(exec_map_base)),
				$past(ea_q[17:9])}))
		else $error("miss did not fetch from the selected page table");

	a_install_slot: assert property ( // RL11
		s_install |=> s_hit_at_slot)
		else $error("installed entry not found in the reload slot");

	a_reload_step: assert property ( // RL10
		(look_hit && (cam.hit_idx == reload_q)) |=> (reload_q == IDX_W'($past(reload_q) + 1'b1)))
		else $error("reload counter failed to advance on its own hit");

	a_reload_hold: assert property ( // RL10
		!(look_hit && (cam.hit_idx == reload_q)) |=> $stable(reload_q))
		else $error("reload counter moved without a hit on its slot");

	a_reset_clear: assert property (disable iff (1'b0) // RL14
		rst |=> (reload_q == '0) && req_ready && !phys_valid && !fail_valid)
		else $error("reset did not clear the translator");

endmodule
`default_nettype wire

/* tb/pat_pt_model.sv */
`timescale 1ns/100ps
`default_nettype none
module pat_pt_model (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        pt_req_valid,
	input  wire logic [21:0] pt_req_addr,
	input  wire logic [3:0]  lat,
	output logic             pt_rsp_valid,
	output logic [15:0]      pt_rsp_data
);
	// ====================
	// Page table words, filled by the bench
	logic [15:0] mem [bit [21:0]];
	int          cnt;

	// Answers after lat waiting cycles; the data word is inverted outside
	// the strobe so a late sample never sees a stale entry
	always @(posedge mclk) begin
		#1;
		if (rst === 1'b1 || pt_rsp_valid) begin
			pt_rsp_valid = 1'b0;
			pt_rsp_data  = ~pt_rsp_data;
			cnt          = 0;
		end else if (pt_req_valid === 1'b1) begin
			if (cnt >= int'(lat)) begin
				pt_rsp_valid = 1'b1;
				pt_rsp_data  = mem.exists(pt_req_addr) ? mem[pt_req_addr] : 16'h0000;
			end else begin
				cnt++;
			end
		end
	end
endmodule
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench;
	typedef struct {
		logic [1:0]  t;
		logic [21:0] v;
		logic [2:0]  c;
		logic        u;
		logic [4:0]  p;
	} pat_note_type;
	// Permitted kinds per access code, bit = kind
	localparam logic [3:0] PM [8] = '{4'h0, 4'h1, 4'h5, 4'h3, 4'h4, 4'h7, 4'h0, 4'h0};

	logic        mclk, rst, req_valid, req_ready, req_user;
	logic [17:0] req_addr, fail_addr;
	logic [1:0]  req_kind;
	logic [12:0] user_map_base, exec_map_base;
	logic        pt_req_valid, pt_rsp_valid, phys_valid, fast_valid, fail_valid, fail_user;
	logic [21:0] pt_req_addr, phys_addr;
	logic [15:0] pt_rsp_data, lf;
	logic [3:0]  fast_idx, lat;
	logic [2:0]  fail_code;
	logic [4:0]  reload_ptr, sp;
	logic [10:0] sk [32];
	logic [15:0] se [32];
	pat_note_type nq[$];
	logic [21:0]  pq[$];
	pat_note_type pn;
	logic         pd, pv;
	int           err_total, num_checks;

	pat_translator #(.ENTRIES(pat_pkg::ENTRIES)) dut (.mclk(mclk), .rst(rst),
		.req_valid(req_valid), .req_ready(req_ready), .req_addr(req_addr),
		.req_user(req_user), .req_kind(req_kind), .user_map_base(user_map_base),
		.exec_map_base(exec_map_base), .pt_req_valid(pt_req_valid),
		.pt_req_addr(pt_req_addr), .pt_rsp_valid(pt_rsp_valid), .pt_rsp_data(pt_rsp_data),
		.phys_valid(phys_valid), .phys_addr(phys_addr), .fast_valid(fast_valid),
		.fast_idx(fast_idx), .fail_valid(fail_valid), .fail_addr(fail_addr),
		.fail_user(fail_user), .fail_code(fail_code), .reload_ptr(reload_ptr));

	pat_pt_model pm (.mclk(mclk), .rst(rst), .pt_req_valid(pt_req_valid),
		.pt_req_addr(pt_req_addr), .lat(lat), .pt_rsp_valid(pt_rsp_valid),
		.pt_rsp_data(pt_rsp_data));

	always #12.5 mclk = ~mclk;

	// ====================
	// Helpers
	function automatic logic [15:0] rnd();
		lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
		return lf;
	endfunction

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task automatic note(input logic ok, input string m);
		num_checks++;
		if (ok !== 1'b1) begin
			err_total++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask

	task automatic chk_phys(input pat_note_type n);
		note({phys_valid, fast_valid, fail_valid} === 3'b100 && phys_addr === n.v, "phys");
	endtask

	task automatic chk_fast(input pat_note_type n);
		note({phys_valid, fast_valid, fail_valid} === 3'b010 && fast_idx === n.v[3:0], "fast");
	endtask

	task automatic chk_fail(input pat_note_type n);
		note({phys_valid, fast_valid, fail_valid} === 3'b001 && fail_addr === n.v[17:0]
			&& fail_user === n.u && fail_code === n.c, "page failure");
	endtask

	task automatic chk_pt(input logic [21:0] a);
		note(pt_req_addr === a, "table fetch address");
	endtask

	task automatic chk_ptr(input logic [4:0] p);
		note(reload_ptr === p, "reload counter");
	endtask

	task automatic pg(input logic u, input logic [8:0] p, input logic [2:0] c);
		logic [15:0] r;
		r = rnd();
		pm.mem[{u ? user_map_base : exec_map_base, p}] = {c, r[12:0]};
	endtask

	// Predicts the result on a shadow map, then offers the request.
	// Leaves req_valid high; the caller lowers it when the burst ends.
	task automatic rq(input logic [17:0] a, input logic u, input logic [1:0] k);
		logic [15:0]  e;
		logic [21:0]  pa;
		pat_note_type n;
		int           h;
		logic         r;
		h = -1;
		n = '{2'h1, {18'h0_0000, a[3:0]}, 3'h0, u, 5'h00};
		if (a > pat_pkg::FAST_LAST) begin
			for (int i = 0; i < 32; i++) if (sk[i] === {1'b1, u, a[17:9]}) h = i;
			if (h < 0) begin
				pa = {u ? user_map_base : exec_map_base, a[17:9]};
				pq.push_back(pa);
				e = pm.mem.exists(pa) ? pm.mem[pa] : 16'h0000;
				sk[sp] = {1'b1, u, a[17:9]};
				se[sp] = e;
				h = sp;
			end
			e = se[h];
			if (h == sp) sp = sp + 5'h01;
			n.t = PM[e[15:13]][k] ? 2'h0 : 2'h2;
			n.v = PM[e[15:13]][k] ? {e[12:0], a[8:0]} : {4'h0, a};
			n.c = e[15:13];
		end
		n.p = sp;
		nq.push_back(n);
		req_addr = a;
		req_user = u;
		req_kind = k;
		req_valid = 1'b1;
		do begin
			@(negedge mclk);
			r = req_ready;
			@(posedge mclk);
		end while (r !== 1'b1);
		#1;
	endtask

	task automatic drain;
		tick(2);
		while (nq.size() != 0 || pq.size() != 0) tick(1);
		tick(2);
	endtask

	task automatic reset_all(input int n);
		rst = 1'b1;
		tick(n);
		rst = 1'b0;
		for (int i = 0; i < 32; i++) sk[i] = 11'h000;
		sp = 5'h00;
		@(negedge mclk);
		note(reload_ptr === 5'h00 && req_ready === 1'b1 && pt_req_valid === 1'b0
			&& {phys_valid, fast_valid, fail_valid} === 3'b000, "reset state");
		tick(1);
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ====================
	// Result watcher
	always @(negedge mclk) begin
		if (rst === 1'b0) begin
			if (pd) chk_ptr(pn.p);
			pd = 1'b0;
			if (pt_req_valid === 1'b1 && !pv) chk_pt(pq.size() ? pq.pop_front() : 22'h3F_FFFF);
			pv = (pt_req_valid === 1'b1);
			if (phys_valid === 1'b1 || fast_valid === 1'b1 || fail_valid === 1'b1) begin
				pn = '{2'h3, 22'h0, 3'h0, 1'b0, 5'h00};
				if (nq.size() != 0) pn = nq.pop_front();
				pd = 1'b1;
				case (pn.t)
					2'h0: chk_phys(pn);
					2'h1: chk_fast(pn);
					2'h2: chk_fail(pn);
					default: note(1'b0, "unexpected result");
				endcase
			end
		end else begin
			pd = 1'b0;
			pv = 1'b0;
		end
	end

	initial begin
		repeat (60000) @(posedge mclk);
		err_total++;
		end_sim();
	end

	// ====================
	// Scenarios
	initial begin
		logic [15:0] r;
		mclk = 1'b0;
		rst = 1'b1;
		req_valid = 1'b0;
		req_addr = 18'h0_0000;
		req_user = 1'b0;
		req_kind = 2'h0;
		user_map_base = 13'h0A51;
		exec_map_base = 13'h1C3E;
		lat = 4'h0;
		lf = 16'h3967;
		pd = 1'b0;
		pv = 1'b0;
		reset_all(20);
		pg(1'b0, 9'h000, 3'h3);
		rq(18'h0_0000, 1'b0, 2'h0);
		rq(18'h0_000F, 1'b1, 2'h1);
		rq(18'h0_0010, 1'b0, 2'h1);
		pg(1'b0, 9'h005, 3'h3);
		pg(1'b1, 9'h005, 3'h1);
		rq(18'h0_0A00, 1'b0, 2'h1);
		rq(18'h0_0BFF, 1'b0, 2'h0);
		rq(18'h0_0A33, 1'b1, 2'h1);
		rq(18'h0_0A34, 1'b1, 2'h0);
		// Every access code against every request kind
		for (int c = 0; c < 8; c++) begin
			pg(1'b0, 9'h040 + 9'(c), 3'(c));
			for (int k = 0; k < 4; k++) begin
				rq({9'h040 + 9'(c), 9'(c * 37)}, 1'b0, 2'(k));
			end
		end
		// 128 keys over 32 slots forces wrap and replacement
		for (int p = 0; p < 128; p++) begin
			r = rnd();
			pg(p[6], 9'h100 + 9'(p[5:0]), r[15:13]);
		end
		for (int n = 0; n < 300; n++) begin
			r = rnd();
			lat = r[12:9];
			rq(r[3:0] == 4'h0 ? {14'h0000, r[8:5]} : {3'h4, r[15:10], r[8:0]}, r[4], r[14:13]);
		end
		req_valid = 1'b0;
		// Reset in mid-run must forget every mapping
		drain();
		reset_all(3);
		rq(18'h0_0A00, 1'b0, 2'h1);
		rq(18'h0_0A01, 1'b0, 2'h1);
		req_valid = 1'b0;
		drain();
		note(nq.size() == 0 && pq.size() == 0, "outstanding results");
		end_sim();
	end
endmodule
`default_nettype wire
